// >>> rtl/eep_cfg.svh
`ifndef EEP_CFG_SVH
`define EEP_CFG_SVH
//------------------------------------------------------------------------------
// Overview of operation
//------------------------------------------------------------------------------
// Overview of operation
// - Data changes only while clock is low.
// - Data falling with clock high is start.
// - Data rising with clock high is stop.
// - Stop after read returns to standby.
// - Words are eight bits, MSB first.
// - Device pulls data low on ninth clock of a matched address or a written word.
// - Standby at power-up and after stop, idle.
// - Host recovers: up to nine clocks, until data reads high, then start.
// - Address match acknowledges; mismatch goes standby.
// - Upper address nibble must be 1010.
// - Address LSB high reads, low writes.
// - Busy write cycle ignores bus, no acknowledge.

//------------------------------------------------------------------------------
// Constants
//------------------------------------------------------------------------------
`define EEP_WORD_BITS   8
`define EEP_ACK_CNT     4'h8
`define EEP_DEV_HI      4'hA
`define EEP_RECOV_MAX   4'h9
`define EEP_MCLK_NS     25
`define EEP_TWR_MS      5
`define EEP_TWR_CYC     ((`EEP_TWR_MS * 1000000) / `EEP_MCLK_NS)
`define EEP_TLOW_NS     1300
`define EEP_HOST_QDIV   ((`EEP_TLOW_NS + 2 * `EEP_MCLK_NS - 1) / (2 * `EEP_MCLK_NS))
`endif

// >>> rtl/eep_pkg.sv
package eep_pkg;
  typedef enum logic [2:0] {
    EEP_CMD_START   = 3'h0,
    EEP_CMD_STOP    = 3'h1,
    EEP_CMD_WRITE   = 3'h2,
    EEP_CMD_READ    = 3'h3,
    EEP_CMD_RECOVER = 3'h4
  } eep_cmd_t;

  typedef enum logic [3:0] {
    EEP_DST_ADDR = 4'b0001,
    EEP_DST_WR   = 4'b0010,
    EEP_DST_RD   = 4'b0100,
    EEP_DST_IGN  = 4'b1000
  } eep_dstate_t;

  typedef enum logic [4:0] {
    EEP_HST_IDLE  = 5'b00001,
    EEP_HST_START = 5'b00010,
    EEP_HST_BITS  = 5'b00100,
    EEP_HST_STOP  = 5'b01000,
    EEP_HST_RECOV = 5'b10000
  } eep_hstate_t;
endpackage

// >>> rtl/eep_if.sv
`timescale 1ns/1ps
interface eep_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic sda;

  // Open-drain wire with pull-up: low when either end drives a low.
  assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));

  modport host (output scl, output host_sda_o, output host_sda_oe, input sda);
  modport dev  (input scl, output dev_sda_o, output dev_sda_oe, input sda);
endinterface

// >>> rtl/eep_dev.sv
`timescale 1ns/1ps
`include "eep_cfg.svh"
module eep_dev #(
  parameter int unsigned TWR_CYC = `EEP_TWR_CYC
) (
  input  wire logic       i_mclk,
  input  wire logic       i_sys_rst,
  eep_if.dev              bus,
  input  wire logic [7:0] i_rd_data,
  input  wire logic       i_rd_valid,
  output logic            o_rd_ready,
  output logic [7:0]      o_rx_data,
  output logic            o_rx_valid,
  output logic            o_busy,
  output logic            o_standby
);
  import eep_pkg::*;

  //----------------------------------------------------------------------------
  // Declarations
  //----------------------------------------------------------------------------
  logic        scl_m1, scl_s, sda_m1, sda_s, sda_p;
  logic        start_w, stop_w;
  logic        frame_q;
  logic        link_rst_q;
  logic        eng_m1, eng_s;
  logic        rx_m1, rx_s, rx_p;
  logic        take_m1, take_s;
  logic        put_q;
  logic [7:0]  stage_q;
  logic        load_w;
  logic        pend_q;
  logic [31:0] twr_q;
  eep_dstate_t st_q;
  logic [3:0]  cnt_q;
  logic [7:0]  shift_q;
  logic [7:0]  tx_q;
  logic [7:0]  rx_q;
  logic        rx_tgl_q;
  logic        take_q;
  logic        put_c1, put_c2;
  logic        busy_c1, busy_c2;
  logic        match_w;
  logic        new_w;

  //----------------------------------------------------------------------------
  // System clock side: pin watch, start and stop
  //----------------------------------------------------------------------------
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      scl_m1 <= 1'b1;
      scl_s  <= 1'b1;
      sda_m1 <= 1'b1;
      sda_s  <= 1'b1;
      sda_p  <= 1'b1;
    end else begin
      scl_m1 <= bus.scl;
      scl_s  <= scl_m1;
      sda_m1 <= bus.sda;
      sda_s  <= sda_m1;
      sda_p  <= sda_s;
    end
  end

  assign start_w = scl_s && sda_p && !sda_s;
  assign stop_w  = scl_s && !sda_p && sda_s;

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      frame_q <= 1'b0;
    end else if (start_w) begin
      frame_q <= 1'b1;
    end else if (stop_w) begin
      frame_q <= 1'b0;
    end
  end

  // The link engine is held in reset from a start or a stop until the clock falls after
  // a start, so the frame's own signals end it even when the clock stands still.
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      link_rst_q <= 1'b1;
    end else if (start_w || stop_w) begin
      link_rst_q <= 1'b1;
    end else if (frame_q && !scl_s) begin
      link_rst_q <= 1'b0;
    end
  end

  //----------------------------------------------------------------------------
  // System clock side: received words, write cycle, standby
  //----------------------------------------------------------------------------
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      eng_m1  <= 1'b0;
      eng_s   <= 1'b0;
      rx_m1   <= 1'b0;
      rx_s    <= 1'b0;
      rx_p    <= 1'b0;
      take_m1 <= 1'b0;
      take_s  <= 1'b0;
    end else begin
      eng_m1  <= (st_q != EEP_DST_IGN);
      eng_s   <= eng_m1;
      rx_m1   <= rx_tgl_q;
      rx_s    <= rx_m1;
      rx_p    <= rx_s;
      take_m1 <= take_q;
      take_s  <= take_m1;
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rx_data  <= 8'h00;
      o_rx_valid <= 1'b0;
    end else begin
      o_rx_valid <= rx_s ^ rx_p;
      if (rx_s ^ rx_p) begin
        o_rx_data <= rx_q;
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pend_q <= 1'b0;
      o_busy <= 1'b0;
      twr_q  <= 32'h0;
    end else begin
      if (rx_s ^ rx_p) begin
        pend_q <= 1'b1;
      end else if (stop_w) begin
        pend_q <= 1'b0;
      end
      if (stop_w && pend_q) begin
        o_busy <= 1'b1;
        twr_q  <= TWR_CYC - 32'h1;
      end else if (o_busy) begin
        if (twr_q == 32'h0) begin
          o_busy <= 1'b0;
        end else begin
          twr_q <= twr_q - 32'h1;
        end
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_standby <= 1'b1;
    end else begin
      o_standby <= !o_busy && !(frame_q && eng_s);
    end
  end

  //----------------------------------------------------------------------------
  // System clock side: read data stage, handed over by toggle
  //----------------------------------------------------------------------------
  assign load_w = i_rd_valid && o_rd_ready;

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      put_q      <= 1'b0;
      stage_q    <= 8'hFF;
      o_rd_ready <= 1'b0;
    end else begin
      if (load_w) begin
        put_q   <= !put_q;
        stage_q <= i_rd_data;
      end
      o_rd_ready <= ((put_q ^ load_w) == take_s);
    end
  end

  //----------------------------------------------------------------------------
  // Link side: bit engine on the rising clock edge
  //----------------------------------------------------------------------------
  assign match_w = (shift_q[7:4] == `EEP_DEV_HI) && !busy_c2;
  assign new_w   = (put_c2 != take_q);

  always_ff @(posedge bus.scl or posedge link_rst_q) begin
    if (link_rst_q) begin
      busy_c1 <= 1'b1;
      busy_c2 <= 1'b1;
    end else begin
      busy_c1 <= o_busy;
      busy_c2 <= busy_c1;
    end
  end

  always_ff @(posedge bus.scl or posedge link_rst_q) begin
    if (link_rst_q) begin
      st_q    <= EEP_DST_ADDR;
      cnt_q   <= 4'h0;
      shift_q <= 8'h00;
    end else if (cnt_q != `EEP_ACK_CNT) begin
      shift_q <= {shift_q[6:0], bus.sda};
      cnt_q   <= cnt_q + 4'h1;
    end else begin
      cnt_q <= 4'h0;
      unique case (st_q)
        EEP_DST_ADDR: st_q <= !match_w ? EEP_DST_IGN : (shift_q[0] ? EEP_DST_RD : EEP_DST_WR);
        EEP_DST_WR:   st_q <= EEP_DST_WR;
        EEP_DST_RD:   st_q <= bus.sda ? EEP_DST_IGN : EEP_DST_RD;
        EEP_DST_IGN:  st_q <= EEP_DST_IGN;
      endcase
    end
  end

  // Crossing toggles keep the system reset only, so frame resets never unpair them.
  always_ff @(posedge bus.scl or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      put_c1   <= 1'b0;
      put_c2   <= 1'b0;
      take_q   <= 1'b0;
      tx_q     <= 8'hFF;
      rx_q     <= 8'h00;
      rx_tgl_q <= 1'b0;
    end else begin
      put_c1 <= put_q;
      put_c2 <= put_c1;
      if (cnt_q == 4'h7 && st_q == EEP_DST_WR) begin
        rx_q     <= {shift_q[6:0], bus.sda};
        rx_tgl_q <= !rx_tgl_q;
      end
      if (cnt_q == `EEP_ACK_CNT && new_w &&
          ((st_q == EEP_DST_ADDR && match_w && shift_q[0]) || (st_q == EEP_DST_RD && !bus.sda))) begin
        tx_q   <= stage_q;
        take_q <= !take_q;
      end
    end
  end

  //----------------------------------------------------------------------------
  // Link side: data drive on the falling clock edge
  //----------------------------------------------------------------------------
  // Changing the drive only at the falling edge keeps the line still while
  // the clock is high; a stale word is resent if no new one was staged.
  always_ff @(negedge bus.scl or posedge link_rst_q) begin
    if (link_rst_q) begin
      bus.dev_sda_oe <= 1'b0;
    end else if (cnt_q == `EEP_ACK_CNT) begin
      unique case (st_q)
        EEP_DST_ADDR: bus.dev_sda_oe <= match_w;
        EEP_DST_WR:   bus.dev_sda_oe <= 1'b1;
        EEP_DST_RD:   bus.dev_sda_oe <= 1'b0;
        EEP_DST_IGN:  bus.dev_sda_oe <= 1'b0;
      endcase
    end else if (st_q == EEP_DST_RD) begin
      bus.dev_sda_oe <= !tx_q[~cnt_q[2:0]];
    end else begin
      bus.dev_sda_oe <= 1'b0;
    end
  end

  always_ff @(negedge bus.scl or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      bus.dev_sda_o <= 1'b0;
    end else begin
      bus.dev_sda_o <= 1'b0;
    end
  end
endmodule

// >>> rtl/eep_host.sv
`timescale 1ns/1ps
`include "eep_cfg.svh"
module eep_host #(
  parameter int unsigned QDIV = `EEP_HOST_QDIV
) (
  input  wire logic             i_mclk,
  input  wire logic             i_sys_rst,
  eep_if.host                   bus,
  input  wire logic             i_cmd_valid,
  input  wire eep_pkg::eep_cmd_t i_cmd,
  input  wire logic [7:0]       i_wdata,
  input  wire logic             i_rd_nack,
  output logic                  o_cmd_ready,
  output logic                  o_done,
  output logic [7:0]            o_rdata,
  output logic                  o_nack
);
  import eep_pkg::*;

  //----------------------------------------------------------------------------
  // Declarations
  //----------------------------------------------------------------------------
  logic        sda_m1, sda_s;
  logic [15:0] div_q;
  logic        tick_w;
  logic [1:0]  q_q;
  logic [3:0]  bit_q;
  logic [8:0]  tx_q;
  eep_hstate_t st_q;

  //----------------------------------------------------------------------------
  // Pin sampling and quarter-bit divider
  //----------------------------------------------------------------------------
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sda_m1 <= 1'b1;
      sda_s  <= 1'b1;
    end else begin
      sda_m1 <= bus.sda;
      sda_s  <= sda_m1;
    end
  end

  assign tick_w = (div_q == 16'(QDIV - 1));

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      div_q <= 16'h0;
    end else if (st_q == EEP_HST_IDLE || tick_w) begin
      div_q <= 16'h0;
    end else begin
      div_q <= div_q + 16'h1;
    end
  end

  //----------------------------------------------------------------------------
  // Sequencer
  //----------------------------------------------------------------------------
  // Each bit spends two quarters low and two high; the line is sampled in
  // the middle of the high half, well after the two-flop delay.
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_q            <= EEP_HST_IDLE;
      q_q             <= 2'h0;
      bit_q           <= 4'h0;
      tx_q            <= 9'h1FF;
      bus.scl         <= 1'b1;
      bus.host_sda_oe <= 1'b0;
      bus.host_sda_o  <= 1'b0;
      o_cmd_ready     <= 1'b0;
      o_done          <= 1'b0;
      o_rdata         <= 8'h00;
      o_nack          <= 1'b0;
    end else begin
      o_done <= 1'b0;
      unique case (st_q)
        EEP_HST_IDLE: begin
          o_cmd_ready <= 1'b1;
          q_q         <= 2'h0;
          bit_q       <= 4'h0;
          if (i_cmd_valid && o_cmd_ready) begin
            o_cmd_ready <= 1'b0;
            unique case (i_cmd)
              EEP_CMD_START:   st_q <= EEP_HST_START;
              EEP_CMD_STOP:    st_q <= EEP_HST_STOP;
              EEP_CMD_WRITE:   st_q <= EEP_HST_BITS;
              EEP_CMD_READ:    st_q <= EEP_HST_BITS;
              EEP_CMD_RECOVER: st_q <= EEP_HST_RECOV;
              default:         st_q <= EEP_HST_IDLE;
            endcase
            tx_q <= (i_cmd == EEP_CMD_READ) ? {8'hFF, i_rd_nack} : {i_wdata, 1'b1};
          end
        end
        EEP_HST_START: if (tick_w) begin
          q_q <= q_q + 2'h1;
          unique case (q_q)
            2'h0: bus.host_sda_oe <= 1'b0;
            2'h1: bus.scl <= 1'b1;
            2'h2: bus.host_sda_oe <= 1'b1;
            2'h3: begin
              bus.scl <= 1'b0;
              st_q    <= EEP_HST_IDLE;
              o_done  <= 1'b1;
            end
          endcase
        end
        EEP_HST_BITS: if (tick_w) begin
          q_q <= q_q + 2'h1;
          unique case (q_q)
            2'h0: bus.host_sda_oe <= !tx_q[8];
            2'h1: bus.scl <= 1'b1;
            2'h2: begin
              if (bit_q == `EEP_ACK_CNT) begin
                o_nack <= sda_s;
              end else begin
                o_rdata <= {o_rdata[6:0], sda_s};
              end
            end
            2'h3: begin
              bus.scl <= 1'b0;
              tx_q    <= {tx_q[7:0], 1'b1};
              bit_q   <= bit_q + 4'h1;
              if (bit_q == `EEP_ACK_CNT) begin
                st_q   <= EEP_HST_IDLE;
                o_done <= 1'b1;
              end
            end
          endcase
        end
        EEP_HST_STOP: if (tick_w) begin
          q_q <= q_q + 2'h1;
          unique case (q_q)
            2'h0: bus.host_sda_oe <= 1'b1;
            2'h1: bus.scl <= 1'b1;
            2'h2: bus.host_sda_oe <= 1'b0;
            2'h3: begin
              st_q   <= EEP_HST_IDLE;
              o_done <= 1'b1;
            end
          endcase
        end
        EEP_HST_RECOV: if (tick_w) begin
          q_q <= q_q + 2'h1;
          unique case (q_q)
            2'h0: bus.host_sda_oe <= 1'b0;
            2'h1: bus.scl <= 1'b1;
            2'h2: begin
              if (sda_s) begin
                // Restart the quarters so the start still gets its falling data edge.
                st_q <= EEP_HST_START;
                q_q  <= 2'h0;
              end
              bit_q <= bit_q + 4'h1;
            end
            2'h3: begin
              bus.scl <= 1'b0;
              if (bit_q == `EEP_RECOV_MAX) begin
                st_q <= EEP_HST_START;
              end
            end
          endcase
        end
      endcase
    end
  end
endmodule

// >>> tb/eep_properties.sv
`timescale 1ns/1ps
module eep_properties #(
  parameter int unsigned TWR_CYC = 400
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic scl,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic sda
);
  // ----
  // Wire tracker
  // ----
  // The busy window is widened by 16 cycles because the device's own
  // busy flag starts a few cycles after the stop through its sync.
  logic        scl_q;
  logic        sda_q;
  logic        ack_q;
  logic        wr_q;
  logic [3:0]  bit_q;
  logic [3:0]  byte_q;
  logic [7:0]  sh_q;
  logic [7:0]  adr_q;
  int unsigned busy_q;
  logic        rise;
  logic        start;
  logic        stop;
  logic        ninth;

  assign rise  = scl && !scl_q;
  assign start = scl && scl_q && sda_q && !sda;
  assign stop  = scl && scl_q && !sda_q && sda;
  assign ninth = rise && bit_q == 4'h8;

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      bit_q  <= 4'h0;
      byte_q <= 4'h0;
      sh_q   <= 8'h00;
      adr_q  <= 8'h00;
      ack_q  <= 1'b0;
    end else if (start || stop) begin
      bit_q  <= 4'h0;
      byte_q <= 4'h0;
      ack_q  <= 1'b0;
    end else if (rise) begin
      sh_q  <= {sh_q[6:0], sda};
      bit_q <= (bit_q == 4'h9) ? 4'h1 : bit_q + 4'h1;
      if (bit_q == 4'h9 && byte_q != 4'hF) begin
        byte_q <= byte_q + 4'h1;
      end
      if (bit_q == 4'h7 && byte_q == 4'h0) begin
        adr_q <= {sh_q[6:0], sda};
      end
      if (ninth && byte_q == 4'h0) begin
        ack_q <= !sda;
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      busy_q <= 0;
      wr_q   <= 1'b0;
    end else if (stop && wr_q) begin
      busy_q <= TWR_CYC + 16;
      wr_q   <= 1'b0;
    end else begin
      if (busy_q != 0) begin
        busy_q <= busy_q - 1;
      end
      if (ninth && byte_q != 4'h0 && ack_q && !adr_q[0]) begin
        wr_q <= 1'b1;
      end
    end
  end

  // ----
  // Properties
  // ----
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);

  property p_dev_open_drain;
    dev_sda_o == 1'b0;
  endproperty
  a_dev_open_drain: assert property (p_dev_open_drain)
    else $error("device drives data line high");

  property p_dev_hold_high;
    scl && $past(scl) |-> $stable(dev_sda_oe);
  endproperty
  a_dev_hold_high: assert property (p_dev_hold_high)
    else $error("device changed data while clock high");

  property p_addr_nack;
    ninth && byte_q == 4'h0 && adr_q[7:4] != 4'hA |-> sda;
  endproperty
  a_addr_nack: assert property (p_addr_nack)
    else $error("foreign address acknowledged");

  property p_addr_ack;
    ninth && byte_q == 4'h0 && adr_q[7:4] == 4'hA && busy_q == 0 |-> !sda;
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("own address not acknowledged");

  property p_busy_nack;
    ninth && byte_q == 4'h0 && busy_q > 16 |-> sda;
  endproperty
  a_busy_nack: assert property (p_busy_nack)
    else $error("address acknowledged during write cycle");

  property p_data_ack;
    ninth && byte_q != 4'h0 && ack_q && !adr_q[0] |-> !sda;
  endproperty
  a_data_ack: assert property (p_data_ack)
    else $error("written byte not acknowledged");

  property p_drive_only;
    scl && scl_q && dev_sda_oe |-> (bit_q == 4'h9 && (byte_q == 4'h0 || !adr_q[0]))
      || (adr_q[0] && ack_q && byte_q != 4'h0 && bit_q != 4'h9 && bit_q != 4'h0);
  endproperty
  a_drive_only: assert property (p_drive_only)
    else $error("device drives data outside ack or read bits");

  property p_stop_idle;
    stop |-> !dev_sda_oe [*8];
  endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("device drives data after stop");
endmodule

// >>> tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  import eep_pkg::*;
  // ----
  // Bench
  // ----
  // A short write cycle keeps the run small but still outlasts one address frame.
  localparam int unsigned TWR = 400;
  logic       i_mclk;
  logic       i_sys_rst;
  logic       cmd_valid;
  logic       rd_nack;
  logic       rd_valid;
  eep_cmd_t   cmd;
  logic [7:0] wdata;
  logic [7:0] rd_data;
  logic [7:0] rdata;
  logic [7:0] rx_data;
  logic [7:0] rx_cnt;
  logic [8:0] wsh;
  logic       cmd_ready;
  logic       done;
  logic       nack;
  logic       rd_ready;
  logic       rx_valid;
  logic       busy;
  logic       standby;
  int         fail_count;
  int         n_checks;

  eep_if bus_if ();
  eep_host #(.QDIV(4)) eep_host_i (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .bus(bus_if.host),
    .i_cmd_valid(cmd_valid), .i_cmd(cmd), .i_wdata(wdata), .i_rd_nack(rd_nack),
    .o_cmd_ready(cmd_ready), .o_done(done), .o_rdata(rdata), .o_nack(nack));
  eep_dev #(.TWR_CYC(TWR)) eep_dev_i (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .bus(bus_if.dev),
    .i_rd_data(rd_data), .i_rd_valid(rd_valid), .o_rd_ready(rd_ready), .o_rx_data(rx_data),
    .o_rx_valid(rx_valid), .o_busy(busy), .o_standby(standby));
  eep_properties #(.TWR_CYC(TWR)) eep_properties_i (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
    .scl(bus_if.scl), .host_sda_o(bus_if.host_sda_o), .host_sda_oe(bus_if.host_sda_oe),
    .dev_sda_o(bus_if.dev_sda_o), .dev_sda_oe(bus_if.dev_sda_oe), .sda(bus_if.sda));

  always #12.5 i_mclk = ~i_mclk;

  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rx_cnt <= 8'h00;
    end else if (rx_valid === 1'b1) begin
      rx_cnt <= rx_cnt + 8'h01;
    end
  end

  always @(posedge bus_if.scl) begin
    wsh <= {wsh[7:0], bus_if.sda};
  end

  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk1(input string nm, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  function automatic logic flag(input int s);
    return (s == 0) ? busy : (s == 1) ? standby : (s == 2) ? cmd_ready : (s == 3) ? done : rd_ready;
  endfunction

  // Waits at falling edges, so a request raised afterwards is taken at the next rising edge.
  task automatic wait_flag(input int s, input logic v);
    int n;
    n = 0;
    while (flag(s) !== v && n < 3000) begin
      @(negedge i_mclk);
      n++;
    end
    if (flag(s) !== v) begin
      fail_count++;
      $display("ERROR flag %0d expected %b seen timeout", s, v);
      print_verdict();
    end
  endtask

  task automatic op(input eep_cmd_t c, input logic [7:0] w, input logic k);
    int n;
    wait_flag(2, 1'b1);
    cmd = c;
    wdata = w;
    rd_nack = k;
    cmd_valid = 1'b1;
    @(negedge i_mclk);
    cmd_valid = 1'b0;
    n = 0;
    do begin
      @(posedge i_mclk);
      #1;
      n++;
    end while (done !== 1'b1 && n < 3000);
    wait_flag(3, 1'b1);
    @(negedge i_mclk);
  endtask

  task automatic stage(input logic [7:0] b);
    wait_flag(4, 1'b1);
    rd_data = b;
    rd_valid = 1'b1;
    @(negedge i_mclk);
    rd_valid = 1'b0;
  endtask

  task automatic frame(input logic [7:0] a, input logic e);
    op(EEP_CMD_START, 8'h00, 1'b0);
    op(EEP_CMD_WRITE, a, 1'b0);
    chk1("address ack", e, nack);
  endtask

  initial begin
    logic [7:0] bad [3];
    bad = '{8'h50, 8'hB0, 8'h2A};
    i_mclk = 1'b0;
    i_sys_rst = 1'b1;
    cmd_valid = 1'b0;
    cmd = EEP_CMD_START;
    wdata = 8'h00;
    rd_nack = 1'b0;
    rd_valid = 1'b0;
    rd_data = 8'h00;
    fail_count = 0;
    n_checks = 0;
    repeat (16) @(negedge i_mclk);
    i_sys_rst = 1'b0;
    chk1("standby", 1'b1, standby);
    chk1("dev oe", 1'b0, bus_if.dev_sda_oe);
    frame(8'hA0, 1'b0);
    op(EEP_CMD_WRITE, 8'h5A, 1'b0);
    chk1("data ack", 1'b0, nack);
    chk8("wire byte", 8'h5A, wsh[8:1]);
    chk8("rx data", 8'h5A, rx_data);
    op(EEP_CMD_WRITE, 8'h81, 1'b0);
    chk8("rx count", 8'h02, rx_cnt);
    op(EEP_CMD_STOP, 8'h00, 1'b0);
    chk1("sda idle", 1'b1, bus_if.sda);
    wait_flag(0, 1'b1);
    chk1("standby busy", 1'b0, standby);
    frame(8'hA0, 1'b1);
    op(EEP_CMD_STOP, 8'h00, 1'b0);
    wait_flag(0, 1'b0);
    wait_flag(1, 1'b1);
    foreach (bad[i]) begin
      frame(bad[i], 1'b1);
      op(EEP_CMD_STOP, 8'h00, 1'b0);
    end
    stage(8'h35);
    frame(8'hA1, 1'b0);
    stage(8'h96);
    op(EEP_CMD_READ, 8'h00, 1'b0);
    chk8("read byte", 8'h35, rdata);
    op(EEP_CMD_READ, 8'h00, 1'b1);
    chk8("read last", 8'h96, rdata);
    op(EEP_CMD_STOP, 8'h00, 1'b0);
    wait_flag(1, 1'b1);
    stage(8'h00);
    frame(8'hA1, 1'b0);
    op(EEP_CMD_RECOVER, 8'h00, 1'b0);
    op(EEP_CMD_WRITE, 8'hA0, 1'b0);
    chk1("ack after recovery", 1'b0, nack);
    op(EEP_CMD_STOP, 8'h00, 1'b0);
    wait_flag(1, 1'b1);
    print_verdict();
  end
endmodule
